// [core/lvdsrx_fifo.v]
// Pixel FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module lvdsrx_fifo #(
  parameter W     = 43,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         clk,        // System clock
  input  wire         reset_n,    // Async reset, active low
  input  wire         in_valid,   // Write request
  output wire         in_ready,   // Space available
  input  wire [W-1:0] in_data,    // Write word
  output reg          out_valid,  // Read word valid
  input  wire         out_ready,  // Consumer takes word
  output reg  [W-1:0] out_data    // Read word
);
  localparam [AW:0] FULL = DEPTH;
  localparam [AW:0] ONE  = 1;
  localparam [AW-1:0] PTR_ONE = 1;

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  assign in_ready = (cnt_q != FULL);
  assign push     = in_valid & in_ready;
  // Refill the output register when the FIFO holds a word and the register is empty or being drained
  assign pop      = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_q  <= {AW{1'b0}};
      rd_ptr_q  <= {AW{1'b0}};
      cnt_q     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {W{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + PTR_ONE;
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + PTR_ONE;
        out_data <= mem[rd_ptr_q];
      end
      if (push & ~pop)
        cnt_q <= cnt_q + ONE;
      else if (pop & ~push)
        cnt_q <= cnt_q - ONE;
      if (pop)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule // lvdsrx_fifo
`default_nettype wire

// [core/lvdsrx_top.v]
// Serialized-link pixel receiver feeding an 800x480 panel
`timescale 1ns/1ps
`default_nettype none
`include "lvdsrx_map.vh"
module lvdsrx_top #(
  parameter        HS_ACTIVE_HIGH = 0,
  parameter        VS_ACTIVE_HIGH = 0,
  parameter        DE_ACTIVE_HIGH = 1,
  parameter [19:0] POWER_ON_CYCLES = `LVDSRX_POWER_ON_CYC,
  parameter        FIFO_DEPTH     = `LVDSRX_FIFO_DEPTH,
  parameter        FIFO_AW        = `LVDSRX_FIFO_AW
) (
  input  wire       clk,                    // System clock, 25 MHz
  input  wire       reset_n,                // Async reset, active low
  input  wire       link_clk,               // Forwarded link clock
  input  wire [6:0] lane_a,                 // Lane a slots 0..6
  input  wire [6:0] lane_b,                 // Lane b slots 0..6
  input  wire [6:0] lane_c,                 // Lane c slots 0..6
  input  wire [6:0] lane_d,                 // Lane d slots 0..6
  input  wire       horizontal_scan_select, // 1 left to right, 0 mirrored
  input  wire       vertical_scan_select,   // 1 top to bottom, 0 flipped
  input  wire       power_down_request,     // High starts shutdown
  input  wire       panel_ready,            // Panel accepts a pixel
  output wire       panel_valid,            // Pixel on panel outputs valid
  output wire [7:0] panel_red,              // Red component
  output wire [7:0] panel_green,            // Green component
  output wire [7:0] panel_blue,             // Blue component
  output wire [9:0] panel_column,           // Scan-ordered column
  output wire [8:0] panel_row,              // Scan-ordered row
  output reg        display_on,             // Image shown
  output reg        shutdown_busy,          // Shutdown sequence running
  output reg        panel_off,              // Shutdown finished
  output reg        overflow                // Pulse: pixel dropped, FIFO full
);
  localparam [5:0] ST_WAIT  = 6'h01;
  localparam [5:0] ST_START = 6'h02;
  localparam [5:0] ST_RUN   = 6'h04;
  localparam [5:0] ST_ARM   = 6'h08;
  localparam [5:0] ST_SHUT  = 6'h10;
  localparam [5:0] ST_OFF   = 6'h20;
  localparam       NIN      = 32;
  localparam       FW       = 43;
  localparam [3:0] CNT_ONE  = 4'h1;
  localparam [9:0] X_ONE    = 10'h001;
  localparam [8:0] Y_ONE    = 9'h001;
  localparam [9:0] H_MAX    = `LVDSRX_H_ACTIVE;
  localparam [8:0] V_MAX    = `LVDSRX_V_ACTIVE;
  localparam [19:0] W_ONE   = 20'h00001;

  // Three-stage sampling of every input pin except clk, reset_n and panel_ready; a bit changes once stages two and three agree
  reg  [NIN-1:0] s1_q;
  reg  [NIN-1:0] s2_q;
  reg  [NIN-1:0] s3_q;
  reg  [NIN-1:0] filt_q;
  wire [NIN-1:0] pins;
  wire [NIN-1:0] filt_d;

  assign pins   = {power_down_request, vertical_scan_select, horizontal_scan_select,
                   link_clk, lane_d, lane_c, lane_b, lane_a};
  assign filt_d = (s3_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q   <= {NIN{1'b0}};
      s2_q   <= {NIN{1'b0}};
      s3_q   <= {NIN{1'b0}};
      filt_q <= {NIN{1'b0}};
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  wire [6:0] la = filt_q[6:0];
  wire [6:0] lb = filt_q[13:7];
  wire [6:0] lc = filt_q[20:14];
  wire [6:0] ld = filt_q[27:21];
  wire       lclk_f = filt_q[28];
  wire       hsel_f = filt_q[29];
  wire       vsel_f = filt_q[30];
  wire       pdr_f  = filt_q[31];

  // Data lanes are stable for a whole link period, so they are taken at the clock's rise
  reg        lclk_prev_q;
  wire       link_rise = lclk_f & ~lclk_prev_q;
  wire [7:0] red   = {la[5:0], ld[1], ld[0]};
  wire [7:0] green = {lb[4:0], la[6], ld[3], ld[2]};
  wire [7:0] blue  = {lc[3:0], lb[6], lb[5], ld[5], ld[4]};
  wire       vs_raw = lc[`LVDSRX_SLOT_VSYNC];
  wire       de_act = (lc[`LVDSRX_SLOT_DE] == (DE_ACTIVE_HIGH != 0));
  wire       vs_act = (vs_raw == (VS_ACTIVE_HIGH != 0));
  wire       hs_act = (lc[`LVDSRX_SLOT_HSYNC] == (HS_ACTIVE_HIGH != 0));

  reg        vs_raw_q;
  reg        vs_act_q;
  reg        de_q;
  reg  [9:0] x_q;
  reg  [8:0] y_q;
  reg  [5:0] state_q;
  reg  [3:0] cnt_q;
  reg  [19:0] wait_q;
  wire       vs_fall  = link_rise & vs_raw_q & ~vs_raw;
  wire       showing  = (state_q == ST_RUN) | (state_q == ST_ARM) | (state_q == ST_SHUT);
  wire       in_frame = (x_q < H_MAX) & (y_q < V_MAX);
  wire       pix_stb  = link_rise & de_act & showing & in_frame;
  wire [9:0] col = hsel_f ? x_q : (`LVDSRX_H_LAST - x_q);
  wire [8:0] row = vsel_f ? y_q : (`LVDSRX_V_LAST - y_q);
  wire       fifo_ready;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lclk_prev_q <= 1'b0;
      vs_raw_q    <= 1'b0;
      vs_act_q    <= 1'b0;
      de_q        <= 1'b0;
      x_q         <= 10'h000;
      y_q         <= 9'h000;
    end
    else
    begin
      lclk_prev_q <= lclk_f;
      if (link_rise)
      begin
        vs_raw_q <= vs_raw;
        vs_act_q <= vs_act;
        de_q     <= de_act;
        // Column counts enabled pixels; a line ends when enable drops
        if (de_act)
          x_q <= x_q + X_ONE;
        else
          x_q <= 10'h000;
        if (vs_act & ~vs_act_q)
          y_q <= 9'h000;
        else if (de_q & ~de_act)
          y_q <= y_q + Y_ONE;
      end
    end
  end

  // Sequencer: start-up blanking, run, shutdown; request ignored before run
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q       <= ST_WAIT;
      cnt_q         <= 4'h0;
      wait_q        <= 20'h00000;
      display_on    <= 1'b0;
      shutdown_busy <= 1'b0;
      panel_off     <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_WAIT:
        begin
          if (wait_q >= POWER_ON_CYCLES - W_ONE)
            state_q <= ST_START;
          else
            wait_q <= wait_q + W_ONE;
          cnt_q <= 4'h0;
        end
        ST_START:
        begin
          if (vs_fall)
          begin
            cnt_q <= cnt_q + CNT_ONE;
            if (cnt_q == `LVDSRX_START_FALLS - CNT_ONE)
              state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (pdr_f)
            state_q <= ST_ARM;
        end
        ST_ARM:
        begin
          cnt_q <= 4'h0;
          if (vs_fall)
            state_q <= ST_SHUT;
        end
        ST_SHUT:
        begin
          if (vs_fall)
          begin
            cnt_q <= cnt_q + CNT_ONE;
            if (cnt_q == `LVDSRX_OFF_PERIODS - CNT_ONE)
              state_q <= ST_OFF;
          end
        end
        ST_OFF:
        begin
          cnt_q <= 4'h0;
          // A released request restarts the start-up count
          if (!pdr_f)
            state_q <= ST_START;
        end
        default:
        begin
          state_q <= ST_WAIT;
          cnt_q   <= 4'h0;
        end
      endcase
      display_on    <= showing;
      shutdown_busy <= (state_q == ST_SHUT);
      panel_off     <= (state_q == ST_OFF);
    end
  end

  // A full FIFO drops the pixel rather than stall: the link cannot be held back
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      overflow <= 1'b0;
    else
      overflow <= pix_stb & ~fifo_ready;
  end

  wire [FW-1:0] fifo_out;
  assign panel_red    = fifo_out[42:35];
  assign panel_green  = fifo_out[34:27];
  assign panel_blue   = fifo_out[26:19];
  assign panel_column = fifo_out[18:9];
  assign panel_row    = fifo_out[8:0];

  lvdsrx_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (pix_stb),
    .in_ready  (fifo_ready),
    .in_data   ({red, green, blue, col, row}),
    .out_valid (panel_valid),
    .out_ready (panel_ready),
    .out_data  (fifo_out)
  );

  wire unused_ok = hs_act;
endmodule // lvdsrx_top
`default_nettype wire

// [dv/lvdsrx_properties.sv]
// Port checks for the panel receiver
`timescale 1ns/1ps
`default_nettype none
module lvdsrx_props (
  input wire logic       clk,           // Clock
  input wire logic       reset_n,       // Reset
  input wire logic [6:0] lane_c,        // Lane c
  input wire logic       panel_ready,   // Ready
  input wire logic       panel_valid,   // Valid
  input wire logic [7:0] panel_red,     // Red
  input wire logic [7:0] panel_green,   // Green
  input wire logic [7:0] panel_blue,    // Blue
  input wire logic [9:0] panel_column,  // Column
  input wire logic [8:0] panel_row,     // Row
  input wire logic       display_on,    // Showing
  input wire logic       shutdown_busy, // Shutting
  input wire logic       panel_off,     // Off
  input wire logic       overflow       // Drop
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_hold;
    panel_valid && !panel_ready |=> panel_valid && $stable({panel_red, panel_green, panel_blue, panel_column, panel_row});
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");
  property p_range;
    panel_valid |-> panel_column <= 10'h31F && panel_row <= 9'h1DF;
  endproperty
  a_range: assert property (p_range) else $error("pixel outside image");
  property p_on_vs;
    $rose(display_on) |-> $past(lane_c[5], 5) == 1'b0;
  endproperty
  a_on_vs: assert property (p_on_vs) else $error("start without frame sync fall");
  property p_off_excl;
    panel_off |-> !shutdown_busy;
  endproperty
  a_off_excl: assert property (p_off_excl) else $error("off while shutting");
  property p_off_from_busy;
    $rose(panel_off) |-> $past(shutdown_busy);
  endproperty
  a_off_from_busy: assert property (p_off_from_busy) else $error("off without shutdown");
  property p_on_fell;
    $fell(display_on) |-> ##[0:1] panel_off;
  endproperty
  a_on_fell: assert property (p_on_fell) else $error("image lost early");
  property p_ovf_gap;
    overflow |=> !overflow [*6];
  endproperty
  a_ovf_gap: assert property (p_ovf_gap) else $error("drop faster than link words");
  property p_ovf_full;
    overflow |-> panel_valid;
  endproperty
  a_ovf_full: assert property (p_ovf_full) else $error("drop with empty output");
  c_on: cover property ($rose(display_on));
  c_ovf: cover property (overflow);
  c_off: cover property ($rose(panel_off));
endmodule // lvdsrx_props
bind lvdsrx_top lvdsrx_props i_lvdsrx_props (.clk(clk), .reset_n(reset_n), .lane_c(lane_c),
  .panel_ready(panel_ready), .panel_valid(panel_valid), .panel_red(panel_red), .panel_green(panel_green),
  .panel_blue(panel_blue), .panel_column(panel_column), .panel_row(panel_row), .display_on(display_on),
  .shutdown_busy(shutdown_busy), .panel_off(panel_off), .overflow(overflow));
`default_nettype wire

// [dv/lvdsrx_tx_model.sv]
// Transmitter model: packs pixel fields into four 7-slot lanes
`timescale 1ns/1ps
`default_nettype none
module lvdsrx_tx_model (
  input  wire logic [7:0] red,      // Red
  input  wire logic [7:0] green,    // Green
  input  wire logic [7:0] blue,     // Blue
  input  wire logic       hs,       // Line sync
  input  wire logic       vs,       // Frame sync
  input  wire logic       de,       // Enable
  output logic            link_clk, // Link clock
  output logic [6:0]      lane_a,   // Lane a
  output logic [6:0]      lane_b,   // Lane b
  output logic [6:0]      lane_c,   // Lane c
  output logic [6:0]      lane_d    // Lane d
);
  // Clock runs free so timing never stops in shutdown; odd offset unties its phase
  initial
  begin
    {lane_a, lane_b, lane_c, lane_d} = 28'h0;
    link_clk = 1'b0;
    #7;
    forever #160 link_clk = ~link_clk;
  end
  // Lanes change mid-period so they are settled around each rising edge
  always @(negedge link_clk)
  begin
    lane_a <= {green[2], red[7:2]};
    lane_b <= {blue[3:2], green[7:3]};
    lane_c <= {de, vs, hs, blue[7:4]};
    lane_d <= {~lane_d[6], blue[1:0], green[1:0], red[1:0]};
  end
endmodule // lvdsrx_tx_model
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the panel receiver
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0, reset_n = 1'b0, ovf_seen = 1'b0, hsel = 1'b1, vsel = 1'b1, pdreq = 1'b0, rdy = 1'b1;
  logic [7:0]  r = 8'h00, g = 8'h00, b = 8'h00;
  logic        hs = 1'b1, vs = 1'b1, de = 1'b0, link_clk;
  logic [6:0]  lane_a, lane_b, lane_c, lane_d;
  wire         pv, don, busy, poff, ovf;
  wire [7:0]   pr, pg, pb;
  wire [9:0]   pcol;
  wire [8:0]   prow;
  int          n_errors = 0, tests_run = 0, cyc = 0, p = 0;
  logic [42:0] got[$], exp_q[$];
  lvdsrx_tx_model i_lvdsrx_tx_model (.red(r), .green(g), .blue(b), .hs(hs), .vs(vs), .de(de),
    .link_clk(link_clk), .lane_a(lane_a), .lane_b(lane_b), .lane_c(lane_c), .lane_d(lane_d));
  lvdsrx_top #(.POWER_ON_CYCLES(20'h10)) i_lvdsrx_top (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .lane_a(lane_a), .lane_b(lane_b), .lane_c(lane_c), .lane_d(lane_d), .horizontal_scan_select(hsel),
    .vertical_scan_select(vsel), .power_down_request(pdreq), .panel_ready(rdy), .panel_valid(pv),
    .panel_red(pr), .panel_green(pg), .panel_blue(pb), .panel_column(pcol), .panel_row(prow),
    .display_on(don), .shutdown_busy(busy), .panel_off(poff), .overflow(ovf));
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (pv === 1'b1 && rdy === 1'b1)
      got.push_back({pr, pg, pb, pcol, prow});
    if (ovf === 1'b1)
      ovf_seen <= 1'b1;
    if (cyc == 6000)
    begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [42:0] a, input logic [42:0] e);
    tests_run++;
    if (a !== e)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  function automatic logic [23:0] pix(input int n);
    return {8'hA5 ^ n[7:0], 8'h3C + n[7:0], 8'h0F ^ {n[3:0], n[7:4]}};
  endfunction
  task automatic word(input logic h, input logic v, input logic d);
    @(posedge link_clk);
    {r, g, b} <= pix(p);
    {hs, vs, de} <= {h, v, d};
    if (d)
      p++;
  endtask
  // A frame opens with a frame sync fall; each line ends with a line sync word
  task automatic frame(input int lines, input int npx, input logic show);
    word(1'b1, 1'b0, 1'b0);
    word(1'b1, 1'b1, 1'b0);
    for (int y = 0; y < lines; y++)
    begin
      for (int x = 0; x < npx; x++)
      begin
        if (show && exp_q.size() < 16)
          exp_q.push_back({pix(p), hsel ? 10'(x) : 10'h31F - 10'(x), vsel ? 9'(y) : 9'h1DF - 9'(y)});
        word(1'b1, 1'b1, 1'b1);
      end
      word(1'b0, 1'b1, 1'b0);
    end
    repeat (12) @(posedge clk);
  endtask
  task automatic flush(input logic exact);
    repeat (24) @(posedge clk);
    if (exact)
      chk(43'(got.size()), 43'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < got.size(); i++)
      chk(got[i], exp_q[i]);
    got.delete();
    exp_q.delete();
  endtask
  task automatic t_start;
    for (int i = 1; i <= 9; i++)
    begin
      frame(2, 3, i == 9);
      chk(43'(don), 43'(i == 9));
    end
    flush(1'b1);
  endtask
  task automatic t_scan;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk);
      #1 {hsel, vsel} = m[1:0];
      frame(2, 3, 1'b1);
      flush(1'b1);
    end
  endtask
  // Stalled panel: the link cannot wait, so words past the buffer are dropped
  task automatic t_ovf;
    @(posedge clk);
    #1 rdy = 1'b0;
    frame(1, 20, 1'b1);
    chk(43'({ovf_seen, pv}), 43'h3);
    @(posedge clk);
    #1 rdy = 1'b1;
    flush(1'b0);
  endtask
  task automatic t_off;
    @(posedge clk);
    #1 pdreq = 1'b1;
    frame(0, 0, 1'b0);
    chk(43'({busy, don}), 43'h3);
    for (int i = 1; i <= 7; i++)
    begin
      frame(0, 0, 1'b0);
      chk(43'(poff), 43'(i == 7));
    end
    frame(1, 3, 1'b0);
    flush(1'b1);
    // Released request: the start-up count runs again from zero
    @(posedge clk);
    #1 pdreq = 1'b0;
    for (int i = 1; i <= 9; i++)
    begin
      frame(0, 0, 1'b0);
      chk(43'({poff, don}), 43'(i == 9));
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (24) @(posedge clk);
    t_start();
    t_scan();
    t_ovf();
    t_off();
    test_done();
  end
endmodule // tb
`default_nettype wire

// [shared/lvdsrx_map.vh]
// Constants for the serialized panel receiver
`ifndef LVDSRX_MAP_VH
`define LVDSRX_MAP_VH
`define LVDSRX_H_ACTIVE      10'd800
`define LVDSRX_V_ACTIVE      9'd480
`define LVDSRX_H_LAST        10'd799
`define LVDSRX_V_LAST        9'd479
`define LVDSRX_COLOR_BITS    8
`define LVDSRX_SLOTS         7
`define LVDSRX_SLOT_HSYNC    4
`define LVDSRX_SLOT_VSYNC    5
`define LVDSRX_SLOT_DE       6
`define LVDSRX_START_FALLS   4'd9
`define LVDSRX_OFF_PERIODS   4'd7
`define LVDSRX_POWER_ON_MS   20
`define LVDSRX_CLK_HZ        25000000
// 20 ms of 25 MHz clock cycles
`define LVDSRX_POWER_ON_CYC  20'd500000
`define LVDSRX_FIFO_DEPTH    16
`define LVDSRX_FIFO_AW       4
`endif
